/* File: kick_cpu_model.sv */
// Processor model that services the watchdog kick input.
// Assumes the bench resolves the reset wire with its pull-up.
`timescale 1ns/100ps
module kick_cpu_model
	import wdt_pkg::*;
(
	// Clock and reset wire
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Servicing mode
	input  wire logic toggle_i,
	input  wire logic float_i,
	// Kick output
	output kick_t     kick_o
);
	int cnt = 0;
	always @(posedge clk_i) begin
		cnt <= (cnt == 59 || !rst_n_i) ? 0 : cnt + 1;
		kick_o.flt <= float_i;
		if (!toggle_i)
			kick_o.lvl <= 1'b0;
		else if (rst_n_i && cnt == 59)
			kick_o.lvl <= ~kick_o.lvl;
	end
endmodule : kick_cpu_model

/* File: supervisor_watchdog_reset.sv */
// Reset pulse generator and watchdog timer of a microprocessor supervisor.
// Assumes supply-low and kick inputs arrive asynchronously from pins.
`timescale 1ns/100ps
module supervisor_watchdog_reset
	import wdt_pkg::*;
#(
	parameter logic [CNT_W-1:0] STRETCH_CNT = CNT_W'(STRETCH_CYC),
	parameter logic [CNT_W-1:0] TIMEOUT_CNT = CNT_W'(TIMEOUT_CYC)
) (
	// Clock and reset
	input  wire logic  SYS_CLK_I,
	input  wire logic  RESET_I,
	// Supply comparator
	input  wire logic  SUPPLY_LOW_I,
	// Watchdog kick input, level and float detect
	input  wire kick_t WATCHDOG_KICK_INPUT_I,
	// Open-drain reset to processor
	output logic       CPU_RST_N_O,
	output logic       CPU_RST_N_OE_N_O
);

	// ----------------------------------------
	// State and next state
	// ----------------------------------------
	wdt_state_t q_ff;
	wdt_state_t nxt_q;
	logic       kick_edge;

	// ----------------------------------------
	// Synchronisers, edge detect, sequencer
	// ----------------------------------------
	always_comb begin
		nxt_q        = q_ff;
		nxt_q.kick_m = WATCHDOG_KICK_INPUT_I.lvl;
		nxt_q.kick_s = q_ff.kick_m;
		nxt_q.flt_m  = WATCHDOG_KICK_INPUT_I.flt;
		nxt_q.flt_s  = q_ff.flt_m;
		nxt_q.low_m  = SUPPLY_LOW_I;
		nxt_q.low_s  = q_ff.low_m;
		nxt_q.kick_d = q_ff.kick_s;
		kick_edge    = (q_ff.kick_s != q_ff.kick_d) && !q_ff.flt_s;
		unique case (q_ff.st)
			ST_HOLD: begin
				nxt_q.wd    = '0;
				nxt_q.rst_n = 1'b0;
				if (q_ff.low_s) begin
					nxt_q.stretch = '0;
				end else if (q_ff.stretch >= STRETCH_CNT - 1'b1) begin
					nxt_q.st      = ST_RUN;
					nxt_q.rst_n   = 1'b1;
					nxt_q.stretch = '0;
				end else begin
					nxt_q.stretch = q_ff.stretch + 1'b1;
				end
			end
			ST_RUN: begin
				nxt_q.rst_n = 1'b1;
				if (q_ff.low_s) begin
					nxt_q.st      = ST_HOLD;
					nxt_q.rst_n   = 1'b0;
					nxt_q.wd      = '0;
					nxt_q.stretch = '0;
				end else if (q_ff.flt_s || kick_edge) begin
					nxt_q.wd = '0;
				end else if (q_ff.wd >= TIMEOUT_CNT - 1'b1) begin
					nxt_q.st      = ST_PULSE;
					nxt_q.rst_n   = 1'b0;
					nxt_q.wd      = '0;
					nxt_q.stretch = '0;
				end else begin
					nxt_q.wd = q_ff.wd + 1'b1;
				end
			end
			ST_PULSE: begin
				nxt_q.rst_n = 1'b0;
				nxt_q.wd    = '0;
				if (q_ff.low_s) begin
					nxt_q.st      = ST_HOLD;
					nxt_q.stretch = '0;
				end else if (q_ff.stretch >= STRETCH_CNT - 1'b1) begin
					nxt_q.st      = ST_RUN;
					nxt_q.rst_n   = 1'b1;
					nxt_q.stretch = '0;
				end else begin
					nxt_q.stretch = q_ff.stretch + 1'b1;
				end
			end
			default: begin
				nxt_q.st    = ST_HOLD;
				nxt_q.rst_n = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			q_ff <= '{st: ST_HOLD, stretch: '0, wd: '0, kick_m: 1'b0, kick_s: 1'b0,
				flt_m: 1'b1, flt_s: 1'b1, kick_d: 1'b0, low_m: 1'b1, low_s: 1'b1,
				rst_n: 1'b0};
		end else begin
			q_ff <= nxt_q;
		end
	end

	// ----------------------------------------
	// Reset output
	// ----------------------------------------
	// Open drain: value always low, enable low pulls
	assign CPU_RST_N_O      = 1'b0;
	assign CPU_RST_N_OE_N_O = q_ff.rst_n;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_low_hold;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		q_ff.low_s |=> !q_ff.rst_n;
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("reset released during supply low");

	property p_stretch;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		$fell(q_ff.rst_n) |-> q_ff.stretch == '0;
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretch not restarted");

	property p_release;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		$rose(q_ff.rst_n) |-> $past(q_ff.stretch) == STRETCH_CNT - 1'b1;
	endproperty
	a_release: assert property (p_release) else $error("reset released early");

	property p_float;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		q_ff.flt_s && q_ff.rst_n && !q_ff.low_s |=> q_ff.wd == '0 && q_ff.rst_n;
	endproperty
	a_float: assert property (p_float) else $error("watchdog ran while floating");

	property p_kick;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		kick_edge && q_ff.st == ST_RUN && !q_ff.low_s |=> q_ff.wd == '0;
	endproperty
	a_kick: assert property (p_kick) else $error("kick did not restart");

	property p_fresh;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		$rose(q_ff.rst_n) |-> q_ff.wd == '0;
	endproperty
	a_fresh: assert property (p_fresh) else $error("time-out not fresh");

	property p_expire;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		q_ff.st == ST_RUN && q_ff.wd == TIMEOUT_CNT - 1'b1 && !kick_edge && !q_ff.flt_s
		&& !q_ff.low_s |=> !q_ff.rst_n;
	endproperty
	a_expire: assert property (p_expire) else $error("no pulse on expiry");

	property p_wd_low;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		q_ff.low_s |=> q_ff.wd == '0;
	endproperty
	a_wd_low: assert property (p_wd_low) else $error("watchdog ran in supply low");

	property p_hold_low;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		q_ff.st == ST_HOLD && q_ff.stretch < STRETCH_CNT - 1'b1 |=> !q_ff.rst_n;
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("power-up stretch cut short");

	property p_hold_end;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		q_ff.st == ST_HOLD && !q_ff.low_s && q_ff.stretch == STRETCH_CNT - 1'b1
		|=> q_ff.st == ST_RUN && q_ff.rst_n;
	endproperty
	a_hold_end: assert property (p_hold_end) else $error("power-up reset not released");

	property p_pulse_low;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		q_ff.st == ST_PULSE && q_ff.stretch < STRETCH_CNT - 1'b1 |=> !q_ff.rst_n;
	endproperty
	a_pulse_low: assert property (p_pulse_low) else $error("watchdog pulse cut short");

	property p_pulse_end;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		q_ff.st == ST_PULSE && !q_ff.low_s && q_ff.stretch == STRETCH_CNT - 1'b1
		|=> q_ff.st == ST_RUN && q_ff.rst_n;
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("watchdog pulse not ended");

	property p_expiry_time;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		$fell(q_ff.rst_n) && !$past(q_ff.low_s) |-> $past(q_ff.wd) == TIMEOUT_CNT - 1'b1;
	endproperty
	a_expiry_time: assert property (p_expiry_time) else $error("early expiry");

	property p_wd_count;
		@(posedge SYS_CLK_I) disable iff (RESET_I)
		q_ff.st == ST_RUN && !q_ff.low_s && !q_ff.flt_s && !kick_edge
		&& q_ff.wd < TIMEOUT_CNT - 1'b1 |=> q_ff.wd == $past(q_ff.wd) + 1'b1;
	endproperty
	a_wd_count: assert property (p_wd_count) else $error("watchdog count stalled");

	c_pulse: cover property (@(posedge SYS_CLK_I) q_ff.st == ST_RUN ##1 q_ff.st == ST_PULSE);
	c_power: cover property (@(posedge SYS_CLK_I) q_ff.st == ST_HOLD ##1 q_ff.st == ST_RUN);
	c_kick: cover property (@(posedge SYS_CLK_I) kick_edge && q_ff.st == ST_RUN);
	c_float: cover property (@(posedge SYS_CLK_I) q_ff.flt_s && q_ff.st == ST_RUN);
	c_brown: cover property (@(posedge SYS_CLK_I) q_ff.st == ST_RUN ##1 q_ff.st == ST_HOLD);

endmodule : supervisor_watchdog_reset

/* File: supervisor_watchdog_reset_tb.sv */
// Self-checking bench for the supervisor reset and watchdog.
// Assumes shortened stretch and time-out counts.
`timescale 1ns/100ps
module supervisor_watchdog_reset_tb;
	import wdt_pkg::*;
	localparam int STR = 20;
	localparam int TMO = 100;
	logic  clk = 0;
	logic  reset = 1;
	logic  supply_low = 1;
	logic  toggle = 0;
	logic  flt = 0;
	kick_t kick;
	logic  rst_n_pin;
	logic  rst_oe_n;
	logic  rst_wire;
	int    fail_count = 0;
	int    checked = 0;
	int    n;
	assign rst_wire = rst_oe_n ? 1'b1 : rst_n_pin;
	supervisor_watchdog_reset #(.STRETCH_CNT(CNT_W'(STR)), .TIMEOUT_CNT(CNT_W'(TMO))) DUT (
		.SYS_CLK_I(clk), .RESET_I(reset), .SUPPLY_LOW_I(supply_low),
		.WATCHDOG_KICK_INPUT_I(kick), .CPU_RST_N_O(rst_n_pin), .CPU_RST_N_OE_N_O(rst_oe_n));
	kick_cpu_model cpu (.clk_i(clk), .rst_n_i(rst_wire), .toggle_i(toggle), .float_i(flt),
		.kick_o(kick));
	initial forever #12.5 clk = ~clk;
	task check(string what, int lo, int hi, int seen);
		checked++;
		if (seen < lo || seen > hi)
			$display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, seen);
		if (seen < lo || seen > hi)
			fail_count++;
	endtask : check
	task wait_for(logic lvl, int lim);
		n = 0;
		while (rst_wire !== lvl && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_for
	task t_supply;
		int h;
		h = 0;
		@(posedge clk) supply_low <= 1'b1;
		wait_for(1'b0, 10);
		check("assert", 0, 5, n);
		repeat (TMO + 20) @(negedge clk) h += int'(rst_wire !== 1'b0);
		check("held", 0, 0, h);
		check("drive", 1, 1, int'(rst_n_pin === 1'b0));
		@(posedge clk) supply_low <= 1'b0;
		wait_for(1'b1, 40);
		check("stretch", STR, STR + 5, n);
		$display("done supply");
	endtask : t_supply
	task t_steady;
		wait_for(1'b0, TMO + 10);
		check("timeout", TMO - 1, TMO + 3, n);
		wait_for(1'b1, STR + 10);
		check("pulse", STR, STR + 1, n);
		wait_for(1'b0, TMO + 10);
		check("repeat", TMO - 1, TMO + 3, n);
		$display("done steady");
	endtask : t_steady
	task t_kick;
		@(posedge clk) toggle <= 1'b1;
		wait_for(1'b1, STR + 10);
		wait_for(1'b0, 3 * TMO);
		check("kicked", 3 * TMO, 3 * TMO, n);
		$display("done kick");
	endtask : t_kick
	task t_brown;
		int h;
		h = 0;
		@(posedge clk) supply_low <= 1'b1;
		wait_for(1'b0, 10);
		check("brown_assert", 1, 5, n);
		repeat (TMO + 20) @(negedge clk) h += int'(rst_wire !== 1'b0);
		check("brown_held", 0, 0, h);
		@(posedge clk) supply_low <= 1'b0;
		wait_for(1'b1, 40);
		check("brown_stretch", STR, STR + 5, n);
		$display("done brown");
	endtask : t_brown
	task t_float;
		@(posedge clk) toggle <= 1'b0;
		flt <= 1'b1;
		wait_for(1'b0, 3 * TMO);
		check("floating", 3 * TMO, 3 * TMO, n);
		$display("done float");
	endtask : t_float
	task finish_test;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		t_supply;
		t_steady;
		t_kick;
		t_brown;
		t_float;
		finish_test;
	end
	initial begin
		#(25 * 3000);
		fail_count++;
		finish_test;
	end
endmodule : supervisor_watchdog_reset_tb

/* File: wdt_pkg.sv */
// Package for the supervisor reset pulse generator and watchdog.
// Assumes a 40 MHz system clock.
package wdt_pkg;

	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned STRETCH_MS      = 140;
	localparam int unsigned TIMEOUT_MS      = 1600;
	localparam longint unsigned STRETCH_CYC = (longint'(STRETCH_MS) * CLK_HZ + 999) / 1000;
	localparam longint unsigned TIMEOUT_CYC = (longint'(TIMEOUT_MS) * CLK_HZ) / 1000;
	localparam int unsigned CNT_W           = 27;

	typedef enum logic [2:0] {
		ST_HOLD  = 3'h1,
		ST_RUN   = 3'h2,
		ST_PULSE = 3'h4
	} wd_state_t;

	typedef struct packed {
		logic lvl;
		logic flt;
	} kick_t;

	typedef struct packed {
		wd_state_t        st;
		logic [CNT_W-1:0] stretch;
		logic [CNT_W-1:0] wd;
		logic             kick_m;
		logic             kick_s;
		logic             flt_m;
		logic             flt_s;
		logic             kick_d;
		logic             low_m;
		logic             low_s;
		logic             rst_n;
	} wdt_state_t;

endpackage : wdt_pkg
